// ==== dpio_pkg.sv ====
/*
  Shared constants of the dual port pin block: port widths, control
  bit positions, reset values and the edge-select encoding.
  Assumes a single instruction clock and synchronous active-low reset.
*/
package dpio_pkg;

  // Port widths
  localparam int unsigned A_WIDTH = 8;
  localparam int unsigned B_WIDTH = 6;
  localparam int unsigned CMP_WIDTH = 4;

  // Reset values: every pin an input, latches low
  localparam logic [7:0] DIR_A_RST = 8'hff;
  localparam logic [5:0] DIR_B_RST = 6'h3f;
  localparam logic [7:0] LATCH_A_RST = 8'h00;
  localparam logic [5:0] LATCH_B_RST = 6'h00;

  // Bit positions inside control words
  localparam int unsigned POWER_CONTROL_REG_PA5_PULLUP_BIT = 4;
  localparam int unsigned APU_PA5_PULLDOWN_BIT = 5;
  localparam int unsigned PD_B_LSB = 4;
  localparam int unsigned GLOBAL_IRQ_BIT = 7;
  localparam int unsigned PORT_CHANGE_IE_BIT = 1;
  localparam int unsigned EXT0_SEL_BIT = 4;
  localparam int unsigned EXT1_SEL_BIT = 5;
  localparam int unsigned EXT0_EDGE_LSB = 0;
  localparam int unsigned EXT1_EDGE_LSB = 2;
  localparam int unsigned OUT_EN_BIT = 7;

  // Pin indices with shared functions
  localparam int unsigned PIN_A_TCLK_B = 1;
  localparam int unsigned PIN_A_TCLK_A = 4;
  localparam int unsigned PIN_A_RESET = 5;
  localparam int unsigned PIN_A_XIN = 6;
  localparam int unsigned PIN_A_XOUT = 7;
  localparam int unsigned PIN_B_EXT0 = 0;
  localparam int unsigned PIN_B_EXT1 = 1;
  localparam int unsigned PIN_B_PWM2 = 2;
  localparam int unsigned PIN_B_PWM1 = 3;

  // Pull-down exists on these port A pins
  localparam logic [7:0] PD_A_MASK = 8'h2f;
  // Pins that are always open-drain on port A
  localparam logic [7:0] OD_A_FIXED = 8'h20;

  // External interrupt edge select encoding
  typedef enum logic [1:0] {
    EDGE_FALL = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_BOTH = 2'h2,
    EDGE_BOTH_ALT = 2'h3
  } dpio_edge_type;

endpackage

// ==== dpio_pin.sv ====
/*
  One pad slice: input synchroniser, change and edge detection,
  and output driver with open-drain option.
  Assumes the pad input is sampled on clk_sys_i.
*/
`timescale 1ns/1ps
module dpio_pin (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic pad_i,
  input wire logic out_val_i,
  input wire logic drive_i,
  input wire logic od_i,
  output logic level_o,
  output logic change_o,
  output logic rise_o,
  output logic fall_o,
  output logic pad_o,
  output logic pad_oe_o
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
  } dpio_pin_state_type;

  dpio_pin_state_type state_reg;
  dpio_pin_state_type state_next;

  always_comb begin
    state_next = state_reg;
    state_next.s1 = pad_i;
    state_next.s2 = state_reg.s1;
    state_next.prev = state_reg.s2;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Compare current sample with previous one
  assign level_o = state_reg.s2;
  assign change_o = state_reg.s2 ^ state_reg.prev;
  assign rise_o = state_reg.s2 & ~state_reg.prev;
  assign fall_o = ~state_reg.s2 & state_reg.prev;

  // Open-drain drives low only, releases high
  assign pad_o = od_i ? 1'b0 : out_val_i;
  assign pad_oe_o = drive_i & (~od_i | ~out_val_i);

endmodule

// ==== dpio_top.sv ====
/*
  Dual port general purpose pin block: two data latches, pad drivers,
  pulls, port-change flag, external interrupt inputs and pin sharing.
  Assumes control words come as plain ports from the processor side.
*/
`timescale 1ns/1ps
module dpio_top #(
  parameter int unsigned A_W = dpio_pkg::A_WIDTH,
  parameter int unsigned B_W = dpio_pkg::B_WIDTH
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [7:0] first_port_pins_i,
  output logic [7:0] first_port_pins_o,
  output logic [7:0] first_port_pins_oe_o,
  input wire logic [5:0] second_port_pins_i,
  output logic [5:0] second_port_pins_o,
  output logic [5:0] second_port_pins_oe_o,
  output logic [7:0] first_port_pullhigh_enable_bar_o,
  output logic [7:0] first_port_pulldown_o,
  output logic [5:0] second_port_pullhigh_enable_bar_o,
  output logic [5:0] second_port_pulldown_o,
  input wire logic first_port_wr_i,
  input wire logic second_port_wr_i,
  input wire logic [7:0] port_wdata_i,
  output logic [7:0] first_port_data_o,
  output logic [5:0] second_port_data_o,
  input wire logic [7:0] first_port_direction_i,
  input wire logic [5:0] second_port_direction_i,
  input wire logic [7:0] first_port_read_latch_i,
  input wire logic [5:0] second_port_read_latch_i,
  input wire logic [7:0] first_port_pullup_ctrl_i,
  input wire logic [7:0] shared_pulldown_ctrl_i,
  input wire logic [5:0] second_port_pullup_ctrl_i,
  input wire logic [5:0] second_port_opendrain_ctrl_i,
  input wire logic [7:0] power_control_reg_i,
  input wire logic [7:0] power_control_second_i,
  input wire logic [7:0] first_port_change_enable_i,
  input wire logic [5:0] second_port_change_enable_i,
  input wire logic [7:0] irq_enable_reg_i,
  input wire logic port_change_clr_i,
  output logic port_change_flag_o,
  output logic irq_req_o,
  input wire logic [7:0] ext_irq_edge_ctrl_i,
  output logic ext_irq0_signal_o,
  output logic ext_irq1_signal_o,
  input wire logic ir_carrier_enable_i,
  input wire logic ir_carrier_i,
  input wire logic reset_pad_enable_i,
  output logic ext_reset_req_o,
  input wire logic crystal_mode_enable_i,
  input wire logic clock_out_enable_i,
  input wire logic timer0_source_select_i,
  input wire logic timer0_lowclk_select_i,
  input wire logic timer1_source_select_i,
  input wire logic timer2_source_select_i,
  input wire logic timer3_source_select_i,
  output logic ext_timer_clock_a_o,
  output logic ext_timer_clock_b_o,
  input wire logic comparator_out_enable_i,
  input wire logic comparator_out_i,
  input wire logic first_pwm_out_enable_i,
  input wire logic first_pwm_i,
  input wire logic first_buzzer_enable_i,
  input wire logic first_buzzer_i,
  input wire logic second_pwm_out_enable_i,
  input wire logic second_pwm_i,
  input wire logic second_buzzer_enable_i,
  input wire logic second_buzzer_i,
  input wire logic [3:0] comparator_plus_route_i,
  input wire logic [3:0] comparator_minus_route_i,
  output logic comparator_plus_o,
  output logic comparator_minus_o,
  input wire logic [5:0] wakeup_enable_bar_i,
  output logic wakeup_o
);

  generate
    if (A_W != 8 || B_W != 6) begin : g_bad_width
      $error("dpio_top supports only 8 and 6 pin ports");
    end
  endgenerate

  typedef struct packed {
    logic [7:0] latch_a;
    logic [5:0] latch_b;
    logic [7:0] rd_a;
    logic [5:0] rd_b;
    logic flag;
    logic ext0;
    logic ext1;
    logic rst_req;
    logic clkout;
    logic tclk_a;
    logic tclk_b;
    logic cmp_p;
    logic cmp_m;
    logic wake;
  } dpio_state_type;

  dpio_state_type state_reg;
  dpio_state_type state_next;

  logic [7:0] lvl_a;
  logic [7:0] chg_a;
  logic [7:0] rise_a;
  logic [7:0] fall_a;
  logic [5:0] lvl_b;
  logic [5:0] chg_b;
  logic [5:0] rise_b;
  logic [5:0] fall_b;
  logic [7:0] out_a;
  logic [7:0] drv_a;
  logic [7:0] od_a;
  logic [5:0] out_b;
  logic [5:0] drv_b;
  logic [5:0] od_b;
  logic [7:0] in_a;
  logic [5:0] in_b;
  logic [5:0] chg_en_b;
  logic chg_hit;
  logic ext0_sel;
  logic ext1_sel;
  logic ext0_evt;
  logic ext1_evt;
  logic [7:0] pu_a;
  logic [7:0] pd_a;
  logic [1:0] edge0;
  logic [1:0] edge1;

  // Direction bit high means input
  assign in_a = first_port_direction_i;
  assign in_b = second_port_direction_i;

  assign ext0_sel = ext_irq_edge_ctrl_i[dpio_pkg::EXT0_SEL_BIT];
  assign ext1_sel = ext_irq_edge_ctrl_i[dpio_pkg::EXT1_SEL_BIT];
  assign edge0 = ext_irq_edge_ctrl_i[dpio_pkg::EXT0_EDGE_LSB +: 2];
  assign edge1 = ext_irq_edge_ctrl_i[dpio_pkg::EXT1_EDGE_LSB +: 2];

  // Port A output values and drive enables
  always_comb begin
    out_a = state_reg.latch_a;
    drv_a = ~in_a;
    od_a = dpio_pkg::OD_A_FIXED;
    if (crystal_mode_enable_i) begin
      drv_a[dpio_pkg::PIN_A_XIN] = 1'b0;
      drv_a[dpio_pkg::PIN_A_XOUT] = 1'b0;
    end else if (clock_out_enable_i) begin
      out_a[dpio_pkg::PIN_A_XOUT] = state_reg.clkout;
      drv_a[dpio_pkg::PIN_A_XOUT] = 1'b1;
    end
    if (reset_pad_enable_i) begin
      drv_a[dpio_pkg::PIN_A_RESET] = 1'b0;
    end
  end

  // Port B output values with fixed-priority sharing
  always_comb begin
    out_b = state_reg.latch_b;
    drv_b = ~in_b;
    od_b = second_port_opendrain_ctrl_i;
    if (comparator_out_enable_i) begin
      out_b[dpio_pkg::PIN_B_PWM1] = comparator_out_i;
      drv_b[dpio_pkg::PIN_B_PWM1] = 1'b1;
      od_b[dpio_pkg::PIN_B_PWM1] = 1'b0;
    end else if (first_pwm_out_enable_i) begin
      out_b[dpio_pkg::PIN_B_PWM1] = first_pwm_i;
      drv_b[dpio_pkg::PIN_B_PWM1] = 1'b1;
      od_b[dpio_pkg::PIN_B_PWM1] = 1'b0;
    end else if (first_buzzer_enable_i) begin
      out_b[dpio_pkg::PIN_B_PWM1] = first_buzzer_i;
      drv_b[dpio_pkg::PIN_B_PWM1] = 1'b1;
      od_b[dpio_pkg::PIN_B_PWM1] = 1'b0;
    end
    if (second_pwm_out_enable_i) begin
      out_b[dpio_pkg::PIN_B_PWM2] = second_pwm_i;
      drv_b[dpio_pkg::PIN_B_PWM2] = 1'b1;
      od_b[dpio_pkg::PIN_B_PWM2] = 1'b0;
    end else if (second_buzzer_enable_i) begin
      out_b[dpio_pkg::PIN_B_PWM2] = second_buzzer_i;
      drv_b[dpio_pkg::PIN_B_PWM2] = 1'b1;
      od_b[dpio_pkg::PIN_B_PWM2] = 1'b0;
    end
    if (ir_carrier_enable_i) begin
      out_b[dpio_pkg::PIN_B_EXT1] = ir_carrier_i;
      drv_b[dpio_pkg::PIN_B_EXT1] = 1'b1;
      od_b[dpio_pkg::PIN_B_EXT1] = 1'b0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin_a
      dpio_pin u_pin (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .pad_i(first_port_pins_i[gi]),
        .out_val_i(out_a[gi]),
        .drive_i(drv_a[gi]),
        .od_i(od_a[gi]),
        .level_o(lvl_a[gi]),
        .change_o(chg_a[gi]),
        .rise_o(rise_a[gi]),
        .fall_o(fall_a[gi]),
        .pad_o(first_port_pins_o[gi]),
        .pad_oe_o(first_port_pins_oe_o[gi])
      );
    end
    for (gi = 0; gi < 6; gi++) begin : g_pin_b
      dpio_pin u_pin (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .pad_i(second_port_pins_i[gi]),
        .out_val_i(out_b[gi]),
        .drive_i(drv_b[gi]),
        .od_i(od_b[gi]),
        .level_o(lvl_b[gi]),
        .change_o(chg_b[gi]),
        .rise_o(rise_b[gi]),
        .fall_o(fall_b[gi]),
        .pad_o(second_port_pins_o[gi]),
        .pad_oe_o(second_port_pins_oe_o[gi])
      );
    end
  endgenerate

  // Pulls act only while the direction bit selects input, even if a shared function drives or releases the pin
  always_comb begin
    pu_a = first_port_pullup_ctrl_i;
    pu_a[dpio_pkg::PIN_A_RESET] = power_control_reg_i[dpio_pkg::POWER_CONTROL_REG_PA5_PULLUP_BIT];
    pd_a = {4'h0, shared_pulldown_ctrl_i[3:0]};
    pd_a[dpio_pkg::PIN_A_RESET] = first_port_pullup_ctrl_i[dpio_pkg::APU_PA5_PULLDOWN_BIT];
    pd_a = pd_a & dpio_pkg::PD_A_MASK;
  end

  assign first_port_pullhigh_enable_bar_o = ~(pu_a & in_a);
  assign first_port_pulldown_o = pd_a & in_a;
  assign second_port_pullhigh_enable_bar_o = ~(second_port_pullup_ctrl_i & in_b);
  assign second_port_pulldown_o =
    {2'h0, shared_pulldown_ctrl_i[dpio_pkg::PD_B_LSB +: 4]} & in_b;

  // External interrupt owns B0/B1 change detection
  always_comb begin
    chg_en_b = second_port_change_enable_i;
    if (ext0_sel) begin
      chg_en_b[dpio_pkg::PIN_B_EXT0] = 1'b0;
    end
    if (ext1_sel) begin
      chg_en_b[dpio_pkg::PIN_B_EXT1] = 1'b0;
    end
  end

  assign chg_hit = |(chg_a & first_port_change_enable_i) | |(chg_b & chg_en_b);

  // Edge qualification for the external interrupt inputs
  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    logic hit;
    hit = 1'b0;
    case (sel)
      dpio_pkg::EDGE_FALL: hit = f;
      dpio_pkg::EDGE_RISE: hit = r;
      dpio_pkg::EDGE_BOTH: hit = r | f;
      dpio_pkg::EDGE_BOTH_ALT: hit = r | f;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  assign ext0_evt = ext0_sel & edge_hit(edge0, rise_b[0], fall_b[0]);
  assign ext1_evt = ext1_sel & edge_hit(edge1, rise_b[1], fall_b[1]);

  always_comb begin
    state_next = state_reg;
    if (first_port_wr_i) begin
      state_next.latch_a = port_wdata_i;
    end
    if (second_port_wr_i) begin
      state_next.latch_b = port_wdata_i[5:0];
    end
    state_next.rd_a = (first_port_read_latch_i & state_reg.latch_a)
                    | (~first_port_read_latch_i & lvl_a);
    state_next.rd_b = (second_port_read_latch_i & state_reg.latch_b)
                    | (~second_port_read_latch_i & lvl_b);
    // Set wins over a clear in the same cycle
    if (chg_hit) begin
      state_next.flag = 1'b1;
    end else if (port_change_clr_i) begin
      state_next.flag = 1'b0;
    end
    state_next.ext0 = ext0_evt;
    state_next.ext1 = ext1_evt;
    state_next.rst_req = reset_pad_enable_i & ~lvl_a[dpio_pkg::PIN_A_RESET];
    state_next.clkout = ~state_reg.clkout;
    state_next.tclk_a = ((timer0_source_select_i & ~timer0_lowclk_select_i)
                       | timer1_source_select_i) & lvl_a[dpio_pkg::PIN_A_TCLK_A];
    state_next.tclk_b = (timer2_source_select_i | timer3_source_select_i)
                      & lvl_a[dpio_pkg::PIN_A_TCLK_B];
    state_next.cmp_p = |(comparator_plus_route_i & lvl_a[3:0]);
    state_next.cmp_m = |(comparator_minus_route_i & lvl_a[3:0]);
    state_next.wake = |(~wakeup_enable_bar_i & chg_b);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign first_port_data_o = state_reg.rd_a;
  assign second_port_data_o = state_reg.rd_b;
  assign port_change_flag_o = state_reg.flag;
  assign irq_req_o = state_reg.flag & irq_enable_reg_i[dpio_pkg::PORT_CHANGE_IE_BIT]
                   & power_control_second_i[dpio_pkg::GLOBAL_IRQ_BIT];
  assign ext_irq0_signal_o = state_reg.ext0;
  assign ext_irq1_signal_o = state_reg.ext1;
  assign ext_reset_req_o = state_reg.rst_req;
  assign ext_timer_clock_a_o = state_reg.tclk_a;
  assign ext_timer_clock_b_o = state_reg.tclk_b;
  assign comparator_plus_o = state_reg.cmp_p;
  assign comparator_minus_o = state_reg.cmp_m;
  assign wakeup_o = state_reg.wake;

  a_flag_on_change: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    chg_hit |=> port_change_flag_o)
    else $error("change flag not set after enabled change");

  a_irq_gating: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    irq_req_o |-> port_change_flag_o && irq_enable_reg_i[1] && power_control_second_i[7])
    else $error("interrupt request without flag and enables");

  a_ext_masks_change: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (ext0_sel && chg_b[0] && {chg_a, chg_b[5:2]} == 12'h0) |=> !$rose(port_change_flag_o))
    else $error("change on selected external pin reached the flag");

  a_opendrain_release: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (second_port_opendrain_ctrl_i[5] && !in_b[5] && state_reg.latch_b[5])
      |-> !second_port_pins_oe_o[5])
    else $error("open-drain pin drove high");

  a_pb3_priority: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (comparator_out_enable_i || first_pwm_out_enable_i) |->
      second_port_pins_oe_o[3] && second_port_pins_o[3] ==
      (comparator_out_enable_i ? comparator_out_i : first_pwm_i))
    else $error("shared pin B3 priority broken");

  a_pb2_priority: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (!second_pwm_out_enable_i && second_buzzer_enable_i) |->
      second_port_pins_o[2] == second_buzzer_i)
    else $error("buzzer not on pin B2");

  a_ir_drive: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ir_carrier_enable_i |-> second_port_pins_oe_o[1] && second_port_pins_o[1] == ir_carrier_i)
    else $error("IR carrier not on pin B1");

  a_xtal_release: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    crystal_mode_enable_i |-> first_port_pins_oe_o[7:6] == 2'h0)
    else $error("crystal pins driven");

  a_reset_pad: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (reset_pad_enable_i && !first_port_pins_i[5]) [*3] |=> ext_reset_req_o)
    else $error("low reset pad did not request reset");

  a_read_latch: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (first_port_read_latch_i == 8'hff && !first_port_wr_i) [*2] |->
      first_port_data_o == state_reg.latch_a)
    else $error("latch read returned other than latch");

endmodule

// ==== dpio_board.sv ====
/*
  Board model for the pads of the dual port pin block.
  Assumes the testbench sets which pads the board drives.
*/
`timescale 1ns/1ps
module dpio_board #(
  parameter int W = 14
) (
  input wire logic clk_i,
  input wire logic [W-1:0] out_i,
  input wire logic [W-1:0] oe_i,
  input wire logic [W-1:0] pu_bar_i,
  input wire logic [W-1:0] pd_i,
  input wire logic [W-1:0] drv_en_i,
  input wire logic [W-1:0] drv_i,
  output logic [W-1:0] pad_o
);
  logic [W-1:0] float_reg = '0;
  // Idle unpulled pads toggle
  always @(posedge clk_i) float_reg <= ~float_reg;
  always_comb begin
    for (int k = 0; k < W; k++) begin
      if (oe_i[k]) pad_o[k] = out_i[k];
      else if (drv_en_i[k]) pad_o[k] = drv_i[k];
      else if (!pu_bar_i[k]) pad_o[k] = 1'h1;
      else if (pd_i[k]) pad_o[k] = 1'h0;
      else pad_o[k] = float_reg[k];
    end
  end
endmodule

// ==== testbench.sv ====
/*
  Self-checking bench of the pin block on a pad board.
  Assumes the package is compiled first.
*/
`timescale 1ns/1ps
module testbench;
  logic clk_sys_i, nrst_i;
  logic [7:0] first_port_direction_i, first_port_read_latch_i, first_port_pullup_ctrl_i;
  logic [7:0] shared_pulldown_ctrl_i, power_control_reg_i, power_control_second_i;
  logic [7:0] first_port_change_enable_i, irq_enable_reg_i, ext_irq_edge_ctrl_i, port_wdata_i;
  logic [5:0] second_port_direction_i, second_port_read_latch_i, second_port_pullup_ctrl_i;
  logic [5:0] second_port_opendrain_ctrl_i, second_port_change_enable_i, wakeup_enable_bar_i;
  logic [3:0] comparator_plus_route_i, comparator_minus_route_i;
  logic first_port_wr_i, second_port_wr_i, port_change_clr_i, ir_carrier_enable_i;
  logic ir_carrier_i, reset_pad_enable_i, crystal_mode_enable_i, clock_out_enable_i;
  logic timer0_source_select_i, timer0_lowclk_select_i, timer1_source_select_i;
  logic timer2_source_select_i, timer3_source_select_i, comparator_out_enable_i, comparator_out_i;
  logic first_pwm_out_enable_i, first_pwm_i, first_buzzer_enable_i, first_buzzer_i;
  logic second_pwm_out_enable_i, second_pwm_i, second_buzzer_enable_i, second_buzzer_i;
  wire logic [7:0] first_port_pins_i;
  wire logic [5:0] second_port_pins_i;
  logic [7:0] first_port_pins_o, first_port_pins_oe_o, first_port_pullhigh_enable_bar_o;
  logic [7:0] first_port_pulldown_o, first_port_data_o;
  logic [5:0] second_port_pins_o, second_port_pins_oe_o, second_port_pullhigh_enable_bar_o;
  logic [5:0] second_port_pulldown_o, second_port_data_o, eo, ev;
  logic port_change_flag_o, irq_req_o, ext_irq0_signal_o, ext_irq1_signal_o, ext_reset_req_o;
  logic ext_timer_clock_a_o, ext_timer_clock_b_o, comparator_plus_o, comparator_minus_o;
  logic wakeup_o, a7;
  logic [13:0] drv_en, drv;
  int n_errors, checked, n_x0, n_x1, n_wake;

  dpio_top dpio_top_inst (.clk_sys_i, .nrst_i, .first_port_pins_i, .first_port_pins_o,
    .first_port_pins_oe_o, .second_port_pins_i, .second_port_pins_o, .second_port_pins_oe_o,
    .first_port_pullhigh_enable_bar_o, .first_port_pulldown_o, .second_port_pulldown_o,
    .second_port_pullhigh_enable_bar_o, .first_port_wr_i, .second_port_wr_i, .port_wdata_i,
    .first_port_data_o, .second_port_data_o, .first_port_direction_i, .second_port_direction_i,
    .first_port_read_latch_i, .second_port_read_latch_i, .first_port_pullup_ctrl_i,
    .shared_pulldown_ctrl_i, .second_port_pullup_ctrl_i, .second_port_opendrain_ctrl_i,
    .power_control_reg_i, .power_control_second_i, .first_port_change_enable_i,
    .second_port_change_enable_i, .irq_enable_reg_i, .port_change_clr_i, .port_change_flag_o,
    .irq_req_o, .ext_irq_edge_ctrl_i, .ext_irq0_signal_o, .ext_irq1_signal_o,
    .ir_carrier_enable_i, .ir_carrier_i, .reset_pad_enable_i, .ext_reset_req_o,
    .crystal_mode_enable_i, .clock_out_enable_i, .timer0_source_select_i,
    .timer0_lowclk_select_i, .timer1_source_select_i, .timer2_source_select_i,
    .timer3_source_select_i, .ext_timer_clock_a_o, .ext_timer_clock_b_o,
    .comparator_out_enable_i, .comparator_out_i, .first_pwm_out_enable_i, .first_pwm_i,
    .first_buzzer_enable_i, .first_buzzer_i, .second_pwm_out_enable_i, .second_pwm_i,
    .second_buzzer_enable_i, .second_buzzer_i, .comparator_plus_route_i,
    .comparator_minus_route_i, .comparator_plus_o, .comparator_minus_o,
    .wakeup_enable_bar_i, .wakeup_o);

  dpio_board #(.W(14)) dpio_board_inst (.clk_i(clk_sys_i),
    .out_i({second_port_pins_o, first_port_pins_o}),
    .oe_i({second_port_pins_oe_o, first_port_pins_oe_o}),
    .pu_bar_i({second_port_pullhigh_enable_bar_o, first_port_pullhigh_enable_bar_o}),
    .pd_i({second_port_pulldown_o, first_port_pulldown_o}), .drv_en_i(drv_en), .drv_i(drv),
    .pad_o({second_port_pins_i, first_port_pins_i}));

  initial begin
    clk_sys_i = 1'h0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  always @(negedge clk_sys_i) begin
    n_x0 += ext_irq0_signal_o;
    n_x1 += ext_irq1_signal_o;
    n_wake += wakeup_o;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task automatic look;
    @(negedge clk_sys_i);
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    n_errors++;
    end_sim;
  end

  initial begin
    {nrst_i, first_port_pullup_ctrl_i, shared_pulldown_ctrl_i, power_control_reg_i,
      power_control_second_i, first_port_change_enable_i, irq_enable_reg_i,
      ext_irq_edge_ctrl_i, port_wdata_i, second_port_pullup_ctrl_i,
      second_port_opendrain_ctrl_i, second_port_change_enable_i, comparator_plus_route_i,
      comparator_minus_route_i, first_port_wr_i, second_port_wr_i, port_change_clr_i,
      ir_carrier_enable_i, ir_carrier_i, reset_pad_enable_i, crystal_mode_enable_i,
      clock_out_enable_i, timer0_source_select_i, timer0_lowclk_select_i,
      timer1_source_select_i, timer3_source_select_i, comparator_out_enable_i,
      comparator_out_i, first_pwm_out_enable_i, first_pwm_i, first_buzzer_enable_i,
      first_buzzer_i, second_pwm_out_enable_i, second_pwm_i, second_buzzer_enable_i,
      second_buzzer_i, timer2_source_select_i, drv_en, drv} = '0;
    {first_port_direction_i, first_port_read_latch_i} = 16'hffff;
    {second_port_direction_i, second_port_read_latch_i} = 12'hfff;
    wakeup_enable_bar_i = 6'h3f;
    tick(8);
    nrst_i <= 1'h1;
    look;
    chk(first_port_data_o, 8'h00);
    tick(1);
    first_port_direction_i <= 8'h00;
    first_port_wr_i <= 1'h1;
    port_wdata_i <= 8'h96;
    tick(1);
    first_port_wr_i <= 1'h0;
    second_port_direction_i <= 6'h00;
    second_port_wr_i <= 1'h1;
    port_wdata_i <= 8'hc5;
    tick(1);
    second_port_wr_i <= 1'h0;
    tick(1);
    look;
    chk(first_port_data_o, 8'h96);
    chk(first_port_pins_o, 8'h96);
    chk(first_port_pins_oe_o, 8'hff);
    chk(8'(second_port_data_o), 8'h05);
    chk(8'(second_port_pins_oe_o), 8'h3f);
    tick(1);
    second_port_read_latch_i <= 6'h00;
    second_port_opendrain_ctrl_i <= 6'h3f;
    drv_en <= 14'h0500;
    drv <= 14'h0400;
    tick(4);
    look;
    chk(8'(second_port_data_o), 8'h04);
    chk(8'(second_port_pins_oe_o), 8'h3a);
    chk(8'(second_port_pins_o & second_port_pins_oe_o), 8'h00);
    tick(1);
    {first_port_direction_i, second_port_direction_i} <= 14'h3fff;
    first_port_pullup_ctrl_i <= 8'h2a;
    power_control_reg_i <= 8'h10;
    shared_pulldown_ctrl_i <= 8'ha5;
    second_port_pullup_ctrl_i <= 6'h15;
    look;
    chk(first_port_pullhigh_enable_bar_o, 8'hd5);
    chk(first_port_pulldown_o, 8'h25);
    chk(8'(second_port_pullhigh_enable_bar_o), 8'h2a);
    chk(8'(second_port_pulldown_o), 8'h0a);
    tick(1);
    power_control_reg_i <= 8'h00;
    first_port_direction_i <= 8'hfe;
    look;
    chk(first_port_pullhigh_enable_bar_o, 8'hf5);
    chk(first_port_pulldown_o, 8'h24);
    tick(1);
    {first_port_pullup_ctrl_i, shared_pulldown_ctrl_i} <= 16'h0000;
    {second_port_pullup_ctrl_i, second_port_opendrain_ctrl_i} <= 12'h000;
    first_port_direction_i <= 8'hff;
    drv_en <= 14'h3fff;
    drv <= 14'h0000;
    tick(4);
    first_port_change_enable_i <= 8'h80;
    second_port_change_enable_i <= 6'h07;
    irq_enable_reg_i <= 8'h02;
    drv <= 14'h0040;
    tick(5);
    look;
    chk(8'(port_change_flag_o), 8'h00);
    tick(1);
    drv <= 14'h00c0;
    tick(2);
    look;
    chk(8'(port_change_flag_o), 8'h00);
    tick(1);
    look;
    chk(8'({port_change_flag_o, irq_req_o}), 8'h02);
    tick(1);
    power_control_second_i <= 8'h80;
    look;
    chk(8'(irq_req_o), 8'h01);
    tick(1);
    irq_enable_reg_i <= 8'h00;
    port_change_clr_i <= 1'h1;
    tick(1);
    port_change_clr_i <= 1'h0;
    look;
    chk(8'({port_change_flag_o, irq_req_o}), 8'h00);
    for (int c = 0; c < 4; c++) begin
      tick(1);
      ext_irq_edge_ctrl_i <= 8'h30 | 8'(c * 5);
      n_x0 = 0;
      n_x1 = 0;
      tick(4);
      drv <= 14'h03c0;
      tick(4);
      drv <= 14'h00c0;
      tick(5);
      look;
      chk(8'(port_change_flag_o), 8'h00);
      chk(8'(n_x0), (c < 2) ? 8'h01 : 8'h02);
      chk(8'(n_x1), (c < 2) ? 8'h01 : 8'h02);
    end
    tick(1);
    wakeup_enable_bar_i <= 6'h3b;
    n_wake = 0;
    drv <= 14'h04c0;
    tick(4);
    drv <= 14'h00c0;
    tick(5);
    look;
    chk(8'(port_change_flag_o), 8'h01);
    chk(8'(n_wake), 8'h02);
    tick(1);
    drv_en <= 14'h00ff;
    {ext_irq_edge_ctrl_i, second_port_change_enable_i} <= 14'h0000;
    for (int i = 0; i < 32; i++) begin
      tick(1);
      {comparator_out_enable_i, first_pwm_out_enable_i, first_buzzer_enable_i} <= i[4:2];
      {second_pwm_out_enable_i, second_buzzer_enable_i, ir_carrier_enable_i} <= i[4:2];
      {comparator_out_i, first_pwm_i, first_buzzer_i} <= {i[0], i[1], ~i[0]};
      {second_pwm_i, second_buzzer_i, ir_carrier_i} <= {i[0], ~i[0], i[1]};
      look;
      eo = {2'h0, |i[4:2], i[4] | i[3], i[2], 1'h0};
      ev = {2'h0, i[4] ? i[0] : (i[3] ? i[1] : ~i[0]), i[4] ? i[0] : ~i[0], i[1], 1'h0} & eo;
      chk(8'(second_port_pins_oe_o & 6'h0e), 8'(eo));
      chk(8'(second_port_pins_o & eo), 8'(ev));
      chk(8'(second_port_pins_o[1] & i[2]), 8'(i[1] & i[2]));
    end
    tick(1);
    first_port_direction_i <= 8'h00;
    drv_en <= 14'h0000;
    crystal_mode_enable_i <= 1'h1;
    look;
    chk(first_port_pins_oe_o & 8'hc0, 8'h00);
    tick(1);
    crystal_mode_enable_i <= 1'h0;
    clock_out_enable_i <= 1'h1;
    look;
    a7 = first_port_pins_o[7];
    look;
    chk(8'({first_port_pins_oe_o[7], first_port_pins_o[7] ^ a7}), 8'h03);
    tick(1);
    clock_out_enable_i <= 1'h0;
    first_port_direction_i <= 8'hff;
    drv_en <= 14'h00ff;
    drv <= 14'h0012;
    timer0_source_select_i <= 1'h1;
    tick(4);
    look;
    chk(8'({ext_timer_clock_a_o, ext_timer_clock_b_o}), 8'h02);
    tick(1);
    timer0_lowclk_select_i <= 1'h1;
    timer2_source_select_i <= 1'h1;
    tick(4);
    look;
    chk(8'({ext_timer_clock_a_o, ext_timer_clock_b_o}), 8'h01);
    tick(1);
    {timer1_source_select_i, timer2_source_select_i, timer3_source_select_i} <= 3'h5;
    drv <= 14'h0016;
    comparator_plus_route_i <= 4'h4;
    comparator_minus_route_i <= 4'h8;
    tick(4);
    look;
    chk(8'({ext_timer_clock_a_o, ext_timer_clock_b_o}), 8'h03);
    chk(8'({comparator_plus_o, comparator_minus_o}), 8'h02);
    tick(1);
    comparator_plus_route_i <= 4'h8;
    comparator_minus_route_i <= 4'h4;
    reset_pad_enable_i <= 1'h1;
    first_port_direction_i <= 8'hdf;
    drv <= 14'h0036;
    tick(4);
    look;
    chk(8'({comparator_plus_o, comparator_minus_o}), 8'h01);
    chk(8'({ext_reset_req_o, first_port_pins_oe_o[5]}), 8'h00);
    tick(1);
    drv <= 14'h0016;
    tick(2);
    look;
    chk(8'(ext_reset_req_o), 8'h00);
    tick(1);
    look;
    chk(8'(ext_reset_req_o), 8'h01);
    end_sim;
  end
endmodule
